/* hw/pps_defines.vh */
// constants and field layout of the power path mode sequencer
// How it works
// - lockout: power-down, pins ignored, battery path on
// - below headroom: pins ignored, input off, floated
// - headroom reached: input-valid low, pins sampled
// - suspend code or overvoltage enters standby
// - valid input: timers on, check pin shorts
// - no short: 100 mA until output rises
// - normal mode keeps re-evaluating pins and input
// - limit pair 00/01/10/11 = 100/500/resistor/suspend
// - input foldback only in 100/500 modes
// - system load has priority over charging
// - output foldback cuts charge, blocks termination
// - supplement enters and leaves on two offsets
// - supplement short: deglitch, off, recover, retry
// - supplement blocks charge termination
// - battery-only short cycling until overload clears
// - charge-enable toggle or suspend exit resets timers
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH
// ----------------------------------------------------------
// input vector bit positions
// ----------------------------------------------------------
`define PPS_IN_W 15
`define PPS_IN_LOCK 0
`define PPS_IN_HEAD 1
`define PPS_IN_OVP 2
`define PPS_IN_OUT_OK 3
`define PPS_IN_SET_SH 4
`define PPS_IN_RES_SH 5
`define PPS_IN_VIN_FB 6
`define PPS_IN_OUT_FB 7
`define PPS_IN_SUP_ENT 8
`define PPS_IN_SUP_EXT 9
`define PPS_IN_SHORT 10
`define PPS_IN_CEN_N 11
`define PPS_IN_SEL_LO 12
`define PPS_IN_SEL_HI 13
`define PPS_IN_SYSTEM_OFF 14
`define PPS_IN_RST 15'h0801
// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define PPS_CLK_MHZ 200
`define PPS_DGL_TIME_US 250
`define PPS_REC_TIME_US 60000
`define PPS_DGL_CYC (`PPS_DGL_TIME_US * `PPS_CLK_MHZ)
`define PPS_REC_CYC (`PPS_REC_TIME_US * `PPS_CLK_MHZ)
`define PPS_CNT_W 24
// ----------------------------------------------------------
// limit codes
// ----------------------------------------------------------
`define PPS_LIM_100 2'b00
`define PPS_LIM_500 2'b01
`define PPS_LIM_RES 2'b10
`define PPS_LIM_SUSP 2'b11
// ----------------------------------------------------------
// register map
// ----------------------------------------------------------
`define PPS_ADDR_W 8
`define PPS_REG_STATUS 8'h00
`define PPS_REG_CTRL 8'h04
`define PPS_REG_IRQ_STAT 8'h08
`define PPS_REG_IRQ_EN 8'h0C
`define PPS_REG_IRQ_CLR 8'h10
`define PPS_CTRL_RST 2'b00
`define PPS_CTRL_SUSP 0
`define PPS_CTRL_HOLD 1
`define PPS_IRQ_W 6
`define PPS_IRQ_RST 6'h00
`define PPS_IRQ_SHORT 0
`define PPS_IRQ_PINSH 1
`define PPS_IRQ_OVP 2
`define PPS_IRQ_NORM 3
`define PPS_IRQ_TMR 4
`define PPS_IRQ_LOCK 5
`endif

/* hw/pps_sequencer.v */
// power path mode sequencer with apb control and status
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.vh"

module pps_sequencer #(
  parameter [`PPS_CNT_W-1:0] DGL_CYC = `PPS_DGL_CYC,
  parameter [`PPS_CNT_W-1:0] REC_CYC = `PPS_REC_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // comparator results
  input wire input_lockout_i,
  input wire headroom_ok_i,
  input wire overvoltage_i,
  input wire output_above_short_i,
  input wire charge_set_pin_short_i,
  input wire limit_resistor_pin_short_i,
  input wire input_voltage_foldback_i,
  input wire output_voltage_foldback_i,
  input wire supplement_enter_i,
  input wire supplement_exit_i,
  input wire output_short_monitor_i,
  // host control pins
  input wire charge_enable_n_i,
  input wire limit_select_lo_i,
  input wire limit_select_hi_i,
  input wire system_off_i,
  // power path controls
  output reg input_switch_o,
  output reg battery_switch_o,
  output reg output_on_o,
  output reg [1:0] input_limit_o,
  output reg input_limit_reduce_o,
  output reg charge_reduce_o,
  output reg supplement_o,
  output reg term_inhibit_o,
  output reg charge_enable_o,
  output reg timers_active_o,
  output reg timer_reset_o,
  // open-drain status pins
  output wire input_valid_n_o,
  output reg input_valid_n_oe_o,
  output wire charge_status_n_o,
  output reg charge_status_n_oe_o,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`PPS_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  // interrupt
  output wire irq_o
);

  // ----------------------------------------------------------
  // states
  // ----------------------------------------------------------
  localparam [6:0] ST_PDOWN = 7'b000_0001;
  localparam [6:0] ST_WAIT = 7'b000_0010;
  localparam [6:0] ST_STBY = 7'b000_0100;
  localparam [6:0] ST_PINCHK = 7'b000_1000;
  localparam [6:0] ST_PINFLT = 7'b001_0000;
  localparam [6:0] ST_SOFT = 7'b010_0000;
  localparam [6:0] ST_NORM = 7'b100_0000;
  localparam [2:0] SC_ON = 3'b001;
  localparam [2:0] SC_DGL = 3'b010;
  localparam [2:0] SC_REC = 3'b100;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  wire [`PPS_IN_W-1:0] raw;
  reg [`PPS_IN_W-1:0] s1_reg;
  reg [`PPS_IN_W-1:0] s2_reg;
  reg [`PPS_IN_W-1:0] s3_reg;
  reg [`PPS_IN_W-1:0] f_reg;
  wire [`PPS_IN_W-1:0] agree;
  wire [`PPS_IN_W-1:0] f_next;

  assign raw = {system_off_i, limit_select_hi_i, limit_select_lo_i,
                charge_enable_n_i, output_short_monitor_i,
                supplement_exit_i, supplement_enter_i,
                output_voltage_foldback_i, input_voltage_foldback_i,
                limit_resistor_pin_short_i, charge_set_pin_short_i,
                output_above_short_i, overvoltage_i, headroom_ok_i,
                input_lockout_i};
  // a bit changes only once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign f_next = (agree & s2_reg) | (~agree & f_reg);

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= `PPS_IN_RST;
      s2_reg <= `PPS_IN_RST;
      s3_reg <= `PPS_IN_RST;
      f_reg <= `PPS_IN_RST;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg <= f_next;
    end
  end

  wire lock = f_reg[`PPS_IN_LOCK];
  wire head = f_reg[`PPS_IN_HEAD];
  wire ovp = f_reg[`PPS_IN_OVP];
  wire [1:0] sel = {f_reg[`PPS_IN_SEL_HI], f_reg[`PPS_IN_SEL_LO]};
  wire pin_short = f_reg[`PPS_IN_SET_SH] | f_reg[`PPS_IN_RES_SH];
  wire cen_n = f_reg[`PPS_IN_CEN_N];

  // ----------------------------------------------------------
  // registers visible to software
  // ----------------------------------------------------------
  reg [1:0] ctrl_reg;
  reg [`PPS_IRQ_W-1:0] irq_stat_reg;
  reg [`PPS_IRQ_W-1:0] irq_stat_next;
  reg [`PPS_IRQ_W-1:0] irq_en_reg;
  reg [`PPS_IRQ_W-1:0] ev;

  // ----------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------
  reg [6:0] st_reg;
  reg [6:0] st_next;
  reg [2:0] sc_reg;
  reg [2:0] sc_next;
  reg [`PPS_CNT_W-1:0] cnt_reg;
  reg [`PPS_CNT_W-1:0] cnt_next;
  reg supp_reg;
  reg supp_next;
  reg cen_prev_reg;
  reg susp_prev_reg;

  wire susp = (sel == `PPS_LIM_SUSP) | ctrl_reg[`PPS_CTRL_SUSP];
  wire valid_in = ~lock & head & ~ovp;
  wire on_input = (st_reg == ST_SOFT) | (st_reg == ST_NORM);
  wire powered = ~(st_reg == ST_PDOWN) & ~(st_reg == ST_WAIT);

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_PDOWN: begin
        if (!lock)
          st_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (head)
          st_next = ST_STBY;
      end
      ST_STBY: begin
        if (valid_in && !susp)
          st_next = ST_PINCHK;
      end
      ST_PINCHK: begin
        if (pin_short)
          st_next = ST_PINFLT;
        else
          st_next = ST_SOFT;
      end
      ST_PINFLT: begin
        if (!pin_short)
          st_next = ST_PINCHK;
      end
      ST_SOFT: begin
        if (f_reg[`PPS_IN_OUT_OK])
          st_next = ST_NORM;
      end
      ST_NORM: begin
        st_next = ST_NORM;
      end
      default: begin
        st_next = ST_PDOWN;
      end
    endcase
    // leaving the valid window drops back from any powered state
    if (powered && (st_reg != ST_STBY)) begin
      if (!head)
        st_next = ST_WAIT;
      else if (ovp || susp)
        st_next = ST_STBY;
    end
    if (powered && (st_reg == ST_STBY) && !head)
      st_next = ST_WAIT;
    if (lock)
      st_next = ST_PDOWN;
  end

  // supplement hysteresis between two offsets
  always @* begin
    supp_next = supp_reg;
    if (!on_input)
      supp_next = 1'b0;
    else if (f_reg[`PPS_IN_SUP_ENT])
      supp_next = 1'b1;
    else if (f_reg[`PPS_IN_SUP_EXT])
      supp_next = 1'b0;
  end

  // short monitor: active on battery-only paths and in supplement
  wire mon = ~on_input | supp_reg;
  wire short_now = mon & f_reg[`PPS_IN_SHORT];

  always @* begin
    sc_next = sc_reg;
    cnt_next = cnt_reg;
    case (sc_reg)
      SC_ON: begin
        cnt_next = {`PPS_CNT_W{1'b0}};
        if (short_now)
          sc_next = SC_DGL;
      end
      SC_DGL: begin
        if (!short_now) begin
          sc_next = SC_ON;
          cnt_next = {`PPS_CNT_W{1'b0}};
        end else if (cnt_reg >= DGL_CYC - 1'b1) begin
          sc_next = SC_REC;
          cnt_next = {`PPS_CNT_W{1'b0}};
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      SC_REC: begin
        if (cnt_reg >= REC_CYC - 1'b1) begin
          sc_next = SC_ON;
          cnt_next = {`PPS_CNT_W{1'b0}};
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        sc_next = SC_ON;
        cnt_next = {`PPS_CNT_W{1'b0}};
      end
    endcase
  end

  // timer restart on charge-enable toggle or suspend exit
  wire tmr_rst = powered & ((cen_n ^ cen_prev_reg) |
                            (susp_prev_reg & ~susp));

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_reg <= ST_PDOWN;
      sc_reg <= SC_ON;
      cnt_reg <= {`PPS_CNT_W{1'b0}};
      supp_reg <= 1'b0;
      cen_prev_reg <= 1'b1;
      susp_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sc_reg <= sc_next;
      cnt_reg <= cnt_next;
      supp_reg <= supp_next;
      cen_prev_reg <= cen_n;
      susp_prev_reg <= susp;
    end
  end

  // ----------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------
  wire sc_off = (sc_reg == SC_REC);
  wire in_norm = (st_reg == ST_NORM);
  wire usb_mode = (sel == `PPS_LIM_100) | (sel == `PPS_LIM_500);
  wire out_fb = in_norm & f_reg[`PPS_IN_OUT_FB];

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      input_switch_o <= 1'b0;
      battery_switch_o <= 1'b1;
      output_on_o <= 1'b1;
      input_limit_o <= `PPS_LIM_100;
      input_limit_reduce_o <= 1'b0;
      charge_reduce_o <= 1'b0;
      supplement_o <= 1'b0;
      term_inhibit_o <= 1'b0;
      charge_enable_o <= 1'b0;
      timers_active_o <= 1'b0;
      timer_reset_o <= 1'b0;
      input_valid_n_oe_o <= 1'b0;
      charge_status_n_oe_o <= 1'b0;
    end else begin
      input_switch_o <= on_input & ~sc_off;
      battery_switch_o <= ~sc_off &
        ~((st_reg == ST_STBY) & f_reg[`PPS_IN_SYSTEM_OFF]);
      output_on_o <= ~sc_off;
      if (in_norm)
        input_limit_o <= sel;
      else
        input_limit_o <= `PPS_LIM_100;
      input_limit_reduce_o <= in_norm & usb_mode &
        f_reg[`PPS_IN_VIN_FB];
      charge_reduce_o <= out_fb | supp_reg;
      supplement_o <= supp_reg;
      term_inhibit_o <= out_fb | supp_reg;
      charge_enable_o <= in_norm & ~cen_n &
        ~ctrl_reg[`PPS_CTRL_HOLD] & ~supp_reg;
      timers_active_o <= powered & (st_reg != ST_STBY);
      timer_reset_o <= tmr_rst;
      input_valid_n_oe_o <= powered;
      charge_status_n_oe_o <= in_norm & ~cen_n &
        ~ctrl_reg[`PPS_CTRL_HOLD];
    end
  end

  // open-drain pins only ever pull low
  assign input_valid_n_o = 1'b0;
  assign charge_status_n_o = 1'b0;

  // ----------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------
  always @* begin
    ev = {`PPS_IRQ_W{1'b0}};
    ev[`PPS_IRQ_SHORT] = (sc_reg == SC_DGL) & (sc_next == SC_REC);
    ev[`PPS_IRQ_PINSH] = (st_reg == ST_PINCHK) & (st_next == ST_PINFLT);
    ev[`PPS_IRQ_OVP] = powered & (st_reg != ST_STBY) &
                       (st_next == ST_STBY) & ovp;
    ev[`PPS_IRQ_NORM] = (st_reg != ST_NORM) & (st_next == ST_NORM);
    ev[`PPS_IRQ_TMR] = tmr_rst;
    ev[`PPS_IRQ_LOCK] = (st_reg != ST_PDOWN) & (st_next == ST_PDOWN);
  end

  // ----------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------
  wire setup = psel_i & ~penable_i;
  wire wr = psel_i & penable_i & pwrite_i;
  reg [31:0] rd_data;
  reg rd_err;

  assign pready_o = 1'b1;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr_i == `PPS_REG_STATUS) begin
      rd_data[6:0] = st_reg;
      rd_data[8:7] = input_limit_o;
      rd_data[9] = supp_reg;
      rd_data[10] = output_on_o;
      rd_data[11] = charge_reduce_o;
      rd_data[12] = input_limit_reduce_o;
      rd_data[13] = charge_enable_o;
    end else if (paddr_i == `PPS_REG_CTRL) begin
      rd_data[1:0] = ctrl_reg;
    end else if (paddr_i == `PPS_REG_IRQ_STAT) begin
      rd_data[`PPS_IRQ_W-1:0] = irq_stat_reg;
    end else if (paddr_i == `PPS_REG_IRQ_EN) begin
      rd_data[`PPS_IRQ_W-1:0] = irq_en_reg;
    end else if (paddr_i == `PPS_REG_IRQ_CLR) begin
      rd_data = 32'h0000_0000;
    end else begin
      rd_err = 1'b1;
    end
  end

  // a new event wins over a clear in the same cycle
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr && (paddr_i == `PPS_REG_IRQ_CLR))
      irq_stat_next = irq_stat_reg & ~pwdata_i[`PPS_IRQ_W-1:0];
    irq_stat_next = irq_stat_next | ev;
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `PPS_CTRL_RST;
      irq_en_reg <= `PPS_IRQ_RST;
      irq_stat_reg <= `PPS_IRQ_RST;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (setup) begin
        prdata_o <= rd_data;
        pslverr_o <= rd_err;
      end
      if (wr && (paddr_i == `PPS_REG_CTRL))
        ctrl_reg <= pwdata_i[1:0];
      if (wr && (paddr_i == `PPS_REG_IRQ_EN))
        irq_en_reg <= pwdata_i[`PPS_IRQ_W-1:0];
    end
  end

endmodule // pps_sequencer
`default_nettype wire

/* tb/pps_host_model.sv */
// host side model that drives the sequencer control pins
`timescale 1ns/100ps
`default_nettype none
module pps_host_model (
  // clock and bench commands {system_off, hi, lo, charge_enable_n}
  input wire logic clk_i,
  input wire logic [3:0] cmd_i,
  // control pins
  output logic charge_enable_n_o,
  output logic limit_select_lo_o,
  output logic limit_select_hi_o,
  output logic system_off_o
);
  // pins start disabled and change only just after a clock edge
  initial {system_off_o, limit_select_hi_o, limit_select_lo_o, charge_enable_n_o} = 4'h1;
  always @(posedge clk_i) begin
    {system_off_o, limit_select_hi_o, limit_select_lo_o, charge_enable_n_o} <= cmd_i;
  end
endmodule // pps_host_model
`default_nettype wire

/* tb/pps_sequencer_assertions.sv */
// port level assertions of the power path sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.vh"
module pps_sequencer_checker #(
  parameter [`PPS_CNT_W-1:0] DGL_CYC = `PPS_DGL_CYC,
  parameter [`PPS_CNT_W-1:0] REC_CYC = `PPS_REC_CYC
) (
  // clock, reset and causes
  input wire logic clk_i, rst_b_i, input_lockout_i, headroom_ok_i, overvoltage_i,
  input wire logic output_short_monitor_i, limit_select_lo_i, limit_select_hi_i,
  // observed outputs
  input wire logic input_switch_o, battery_switch_o, output_on_o, input_limit_reduce_o,
  input wire logic charge_reduce_o, supplement_o, term_inhibit_o, timer_reset_o,
  input wire logic input_valid_n_oe_o, charge_status_n_oe_o,
  input wire logic [1:0] input_limit_o
);
  logic [`PPS_CNT_W-1:0] short_cnt_reg, off_cnt_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // run lengths of the short condition and of the output off time
  always_ff @(posedge clk_i) begin
    short_cnt_reg <= (!rst_b_i || !output_short_monitor_i) ? '0 : short_cnt_reg + 1'b1;
    off_cnt_reg <= (!rst_b_i || output_on_o) ? '0 : off_cnt_reg + 1'b1;
  end
  a_lock_all_off: assert property (input_lockout_i [*8] |->
    !input_switch_o && !input_valid_n_oe_o && !charge_status_n_oe_o) else $error("lockout outputs");
  a_wait_off: assert property (!headroom_ok_i [*8] |->
    !input_switch_o && !input_valid_n_oe_o) else $error("no headroom outputs");
  a_suspend_stby: assert property ((!input_lockout_i && headroom_ok_i && limit_select_hi_i && limit_select_lo_i) [*8]
    |-> !input_switch_o && input_valid_n_oe_o) else $error("suspend outputs");
  a_ovp_stby: assert property (overvoltage_i [*8] |-> !input_switch_o) else $error("ovp switch");
  a_limit_code: assert property ($stable({limit_select_hi_i, limit_select_lo_i}) [*8] ##0 input_limit_o != 2'b00
    |-> input_limit_o == {limit_select_hi_i, limit_select_lo_i}) else $error("limit code");
  a_fold_usb_only: assert property (input_limit_reduce_o |-> input_limit_o != 2'b10) else $error("fold mode");
  a_term_block: assert property (supplement_o || charge_reduce_o |-> term_inhibit_o) else $error("term");
  a_short_deglitch: assert property ($fell(output_on_o) |->
    short_cnt_reg >= DGL_CYC && !battery_switch_o) else $error("short off early");
  a_recover_len: assert property ($rose(output_on_o) |->
    off_cnt_reg + 2 >= REC_CYC && off_cnt_reg <= REC_CYC + 2) else $error("recovery length");
  a_timer_pulse: assert property (timer_reset_o |=> !timer_reset_o) else $error("timer pulse");
endmodule // pps_sequencer_checker
bind pps_sequencer pps_sequencer_checker #(.DGL_CYC(DGL_CYC), .REC_CYC(REC_CYC)) chk_u (.clk_i, .rst_b_i,
  .input_lockout_i, .headroom_ok_i, .overvoltage_i, .output_short_monitor_i, .limit_select_lo_i,
  .limit_select_hi_i, .input_switch_o, .battery_switch_o, .output_on_o, .input_limit_reduce_o,
  .charge_reduce_o, .supplement_o, .term_inhibit_o, .timer_reset_o, .input_valid_n_oe_o,
  .charge_status_n_oe_o, .input_limit_o);
`default_nettype wire

/* tb/pps_sequencer_test.sv */
// self-checking bench of the power path sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.vh"
module pps_sequencer_test;
  localparam int DGL = 20;
  localparam int REC = 40;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [`PPS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [`PPS_IN_W-1:0] in_v = `PPS_IN_RST;
  logic cen_n, sel_lo, sel_hi, system_off, in_sw, bat_sw, out_on, red_in, red_chg, sup, term, chg_en, tmr_on;
  logic tmr_rst, iv_oe, cs_oe, pready, pslverr, irq, iv_n, cs_n;
  logic [1:0] lim;
  int n_errors = 0, n_compared = 0, c, k;
  always #2.5 clk = ~clk;
  pps_host_model host_u (.clk_i(clk), .cmd_i(in_v[`PPS_IN_SYSTEM_OFF:`PPS_IN_CEN_N]), .charge_enable_n_o(cen_n),
    .limit_select_lo_o(sel_lo), .limit_select_hi_o(sel_hi), .system_off_o(system_off));
  pps_sequencer #(.DGL_CYC(DGL), .REC_CYC(REC)) dut_u (.clk_i(clk), .rst_b_i(rst_b),
    .input_lockout_i(in_v[`PPS_IN_LOCK]), .headroom_ok_i(in_v[`PPS_IN_HEAD]), .overvoltage_i(in_v[`PPS_IN_OVP]),
    .output_above_short_i(in_v[`PPS_IN_OUT_OK]), .charge_set_pin_short_i(in_v[`PPS_IN_SET_SH]),
    .limit_resistor_pin_short_i(in_v[`PPS_IN_RES_SH]), .input_voltage_foldback_i(in_v[`PPS_IN_VIN_FB]),
    .output_voltage_foldback_i(in_v[`PPS_IN_OUT_FB]), .supplement_enter_i(in_v[`PPS_IN_SUP_ENT]),
    .supplement_exit_i(in_v[`PPS_IN_SUP_EXT]), .output_short_monitor_i(in_v[`PPS_IN_SHORT]),
    .charge_enable_n_i(cen_n), .limit_select_lo_i(sel_lo), .limit_select_hi_i(sel_hi), .system_off_i(system_off),
    .input_switch_o(in_sw), .battery_switch_o(bat_sw), .output_on_o(out_on), .input_limit_o(lim),
    .input_limit_reduce_o(red_in), .charge_reduce_o(red_chg), .supplement_o(sup), .term_inhibit_o(term),
    .charge_enable_o(chg_en), .timers_active_o(tmr_on), .timer_reset_o(tmr_rst), .input_valid_n_o(iv_n),
    .input_valid_n_oe_o(iv_oe), .charge_status_n_o(cs_n), .charge_status_n_oe_o(cs_oe), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // only the watchdog ends a wait for the answer
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic state(input logic [6:0] exp);
    apb(0, `PPS_REG_STATUS, 0);
    chk("state", rd[6:0], exp);
  endtask
  task automatic wait_out(input logic v);
    c = 0;
    while (out_on !== v && c < 300) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic pulses();
    c = 0;
    repeat (12) begin
      @(posedge clk);
      if (tmr_rst === 1'b1) c++;
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_lock();
    in_v[`PPS_IN_SEL_HI] <= 1;
    in_v[`PPS_IN_CEN_N] <= 0;
    wt(10);
    chk("in_sw", {in_sw, bat_sw, iv_oe, cs_oe, chg_en}, 5'h08);
    state(7'h01);
    in_v[`PPS_IN_LOCK] <= 0;
    wt(10);
    state(7'h02);
    chk("wait_pins", {in_sw, bat_sw, iv_oe, cs_oe}, 4'h4);
    apb(0, `PPS_REG_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(0, 8'h14, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    chk("pready", pready, 1);
  endtask
  task automatic t_start();
    in_v[`PPS_IN_SET_SH] <= 1;
    in_v[`PPS_IN_SEL_HI] <= 0;
    in_v[`PPS_IN_HEAD] <= 1;
    wt(10);
    state(7'h10);
    chk("pinfault", {in_sw, iv_oe}, 2'h1);
    in_v[`PPS_IN_SET_SH] <= 0;
    wt(10);
    state(7'h20);
    chk("soft", {in_sw, lim, tmr_on}, 4'h9);
    in_v[`PPS_IN_OUT_OK] <= 1;
    wt(10);
    state(7'h40);
    chk("normal", {cs_oe, chg_en}, 2'h3);
    chk("od_pins", {iv_n, cs_n}, 2'h0);
  endtask
  task automatic t_modes();
    for (k = 0; k < 3; k++) begin
      in_v[`PPS_IN_SEL_HI:`PPS_IN_SEL_LO] <= k[1:0];
      wt(10);
      chk("limit", lim, k[1:0]);
    end
    in_v[`PPS_IN_SEL_HI:`PPS_IN_SEL_LO] <= 2'h3;
    wt(10);
    state(7'h04);
    chk("stby", {in_sw, bat_sw, iv_oe}, 3'h3);
    in_v[`PPS_IN_SYSTEM_OFF] <= 1;
    wt(10);
    chk("system_off", bat_sw, 0);
    in_v[`PPS_IN_SYSTEM_OFF] <= 0;
    in_v[`PPS_IN_SEL_HI:`PPS_IN_SEL_LO] <= 2'h0;
    pulses();
    chk("tmr_susp", c, 1);
    wt(20);
    in_v[`PPS_IN_CEN_N] <= 1;
    pulses();
    chk("tmr_ce", {c[3:0], chg_en}, 5'h02);
    in_v[`PPS_IN_CEN_N] <= 0;
    wt(10);
  endtask
  task automatic t_fold();
    in_v[`PPS_IN_VIN_FB] <= 1;
    wt(10);
    chk("vin_fb", red_in, 1);
    in_v[`PPS_IN_SEL_HI] <= 1;
    wt(10);
    chk("vin_fb_res", red_in, 0);
    in_v[`PPS_IN_VIN_FB] <= 0;
    in_v[`PPS_IN_SEL_HI] <= 0;
    in_v[`PPS_IN_OUT_FB] <= 1;
    wt(10);
    chk("out_fb", {red_chg, term}, 2'h3);
    in_v[`PPS_IN_OUT_FB] <= 0;
    in_v[`PPS_IN_SUP_ENT] <= 1;
    wt(10);
    chk("sup_on", {sup, term}, 2'h3);
    in_v[`PPS_IN_SUP_ENT] <= 0;
    in_v[`PPS_IN_SUP_EXT] <= 1;
    wt(10);
    chk("sup_off", sup, 0);
    in_v[`PPS_IN_SUP_EXT] <= 0;
  endtask
  task automatic t_short();
    apb(1, `PPS_REG_IRQ_EN, 1);
    in_v[`PPS_IN_SUP_ENT] <= 1;
    in_v[`PPS_IN_SHORT] <= 1;
    wait_out(0);
    chk("short_off", {out_on, in_sw, bat_sw, irq}, 4'h1);
    wait_out(1);
    chk("retry_on", out_on, 1);
    wait_out(0);
    chk("retry_off", out_on, 0);
    in_v[`PPS_IN_SHORT] <= 0;
    in_v[`PPS_IN_SUP_ENT] <= 0;
    in_v[`PPS_IN_SUP_EXT] <= 1;
    wait_out(1);
    wt(10);
    in_v[`PPS_IN_SUP_EXT] <= 0;
    apb(1, `PPS_REG_IRQ_CLR, 1);
    apb(0, `PPS_REG_IRQ_STAT, 0);
    chk("irq_clr", {rd[0], irq}, 2'h0);
    apb(1, `PPS_REG_IRQ_EN, 0);
    in_v[`PPS_IN_LOCK] <= 1;
    in_v[`PPS_IN_SHORT] <= 1;
    wait_out(0);
    chk("bat_short", {out_on, irq}, 2'h0);
    apb(0, `PPS_REG_IRQ_STAT, 0);
    chk("irq_stat", rd[5:0], 6'h3B);
    in_v[`PPS_IN_SHORT] <= 0;
    wait_out(1);
    chk("bat_back", out_on, 1);
  endtask
  task automatic t_ovp();
    in_v[`PPS_IN_LOCK] <= 0;
    wt(20);
    state(7'h40);
    // overvoltage must strike from a running state to raise its event
    in_v[`PPS_IN_OVP] <= 1;
    wt(20);
    state(7'h04);
    chk("ovp", {in_sw, iv_oe}, 2'h1);
    apb(0, `PPS_REG_IRQ_STAT, 0);
    chk("irq_ovp", rd[2], 1);
    in_v[`PPS_IN_OVP] <= 0;
    wt(20);
    state(7'h40);
    apb(1, `PPS_REG_CTRL, 2);
    wt(10);
    chk("hold", {chg_en, cs_oe, iv_oe}, 3'h1);
    apb(1, `PPS_REG_CTRL, 1);
    wt(10);
    state(7'h04);
    apb(0, `PPS_REG_CTRL, 0);
    chk("ctrl_rd", rd, 32'h0000_0001);
    apb(1, `PPS_REG_CTRL, 0);
    wt(20);
    state(7'h40);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1;
    t_lock();
    t_start();
    t_modes();
    t_fold();
    t_short();
    t_ovp();
    give_verdict();
  end
endmodule // pps_sequencer_test
`default_nettype wire
